/* slps_pkg.sv */
// Package for the stream link port status block: command codes, status layout, carriers.
// Assumes a single processor clock domain; used by the design, the monitor, the user model and the bench.
package slps_pkg;

  localparam int unsigned LINK_NUM       = 8;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned LINK_IDX_W     = 3;
  // Big-endian bit numbering: bit n sits at little-endian position 31-n
  localparam int unsigned STAT_MSB_POS   = 31;  // bit 0, copy of carry
  localparam int unsigned STAT_CARRY_POS = 2;   // bit 29, mask 0x4
  localparam int unsigned STAT_LERR_POS  = 4;   // bit 27, mask 0x10
  localparam logic [31:0] STAT_CARRY_MASK = 32'h0000_0004;
  localparam logic [31:0] STAT_LERR_MASK  = 32'h0000_0010;
  localparam logic [31:0] STAT_RESET      = 32'h0000_0000;
  localparam logic        TAG_DATA        = 1'h0;
  localparam logic        TAG_CONTROL     = 1'h1;
  localparam logic [1:0]  BUF_PTR_RESET   = 2'h0;

  typedef enum logic [1:0] {
    SLPS_OP_READ  = 2'h0,
    SLPS_OP_WRITE = 2'h1,
    SLPS_OP_STAT  = 2'h2
  } slps_op_t;

  // Tagged word on a link
  typedef struct packed {
    logic              tag;
    logic [DATA_W-1:0] data;
  } slps_word_t;

  // Link instruction from the processor pipeline
  typedef struct packed {
    slps_op_t                op;
    logic                    blocking;
    logic                    control;
    logic [LINK_IDX_W-1:0]   link;
    logic [DATA_W-1:0]       data;
  } slps_cmd_t;

  typedef enum logic [2:0] {
    SLPS_ST_IDLE = 3'b001,
    SLPS_ST_WAIT = 3'b010,
    SLPS_ST_DONE = 3'b100
  } slps_state_t;

endpackage

/* slps_top.sv */
// Processor-side link port logic: eight inbound and eight outbound tagged stream links
// plus the status word carry and link-error flags.
// Assumes far-end user logic on the same clock; commands come from the processor pipeline.
// Behaviour
// - Data-type write places word on link with tag zero.
// - Control-type write places word on link with tag one.
// - Blocking transfer stalls processor until the transfer can happen.
// - Non-blocking transfer never stalls and completes even when it fails.
// - Read from a link holding no word fails as data invalid.
// - Control read of a word with tag cleared signals link error.
// - Data read of a word with tag set signals link error.
// - Data invalid sets carry flag, status bit 29, mask 0x4.
// - Carry flag is copied into most significant status bit 0.
// - Link error sets link-error flag, status bit 27, mask 0x10.
// - Write to a full link fails as data invalid.
// - Software reads the whole status word with a status move.
// - Status bits numbered big-endian, bit 0 is most significant.
// - Sixteen links: eight inbound receive, eight outbound send.
// - Inbound and outbound user ports 0 to 7 map to connections 0 to 7.
// - Link index selects a bus connection, not a buffer instance.
// - Non-empty drops when empty; an empty read yields undefined data.
`timescale 1ns/1ps

// Two-entry buffer, valid/ready on both sides
module slps_buf #(
  parameter int unsigned W = 33
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_word,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_word
);
  if (W < 1) begin : g_bad_w
    $error("slps_buf: W must be at least 1");
  end

  logic [W-1:0] mem_q [2];
  logic [1:0]   cnt_q;
  logic         wr_ptr_q;
  logic         rd_ptr_q;
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_word  = mem_q[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q    <= slps_pkg::BUF_PTR_RESET;
      wr_ptr_q <= 1'h0;
      rd_ptr_q <= 1'h0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      cnt_q <= cnt_q + {1'h0, push} - {1'h0, pop};
    end
  end

  // Storage needs no reset; a failed processor read still copies out_word into cmd_rdata
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wr_ptr_q] <= in_word;
    end
  end
endmodule

// One link pair: inbound buffer and full flag, outbound buffer and present register
module slps_lane #(
  parameter int unsigned W = 33
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  // Inbound user port
  input  wire logic         in_write,
  input  wire logic [W-1:0] in_word,
  output logic              in_full,
  // Inbound processor side
  output logic              ib_valid,
  input  wire logic         ib_pop,
  output logic [W-1:0]      ib_word,
  // Outbound processor side
  input  wire logic         ob_push,
  output logic              ob_ready,
  input  wire logic [W-1:0] ob_in,
  // Outbound user port
  input  wire logic         out_read,
  output logic [W-1:0]      out_word,
  output logic              out_exists
);
  if (W < 2) begin : g_bad_w
    $error("slps_lane: W must hold a tag and data");
  end

  logic         ib_ready;
  logic         ob_valid;
  logic [W-1:0] ob_word;
  logic         take;
  logic         in_full_q;
  logic         out_exists_q;
  logic [W-1:0] out_word_q;

  slps_buf #(.W(W)) u_in (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_valid  (in_write && !in_full_q),
    .in_ready  (ib_ready),
    .in_word   (in_word),
    .out_valid (ib_valid),
    .out_ready (ib_pop),
    .out_word  (ib_word)
  );

  slps_buf #(.W(W)) u_out (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_valid  (ob_push),
    .in_ready  (ob_ready),
    .in_word   (ob_in),
    .out_valid (ob_valid),
    .out_ready (take),
    .out_word  (ob_word)
  );

  // Present register is a one-deep stage in front of the user
  assign take = ob_valid && (!out_exists_q || out_read);

  // Registered full flag also counts this cycle's push, so no write is lost
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_full_q <= 1'h0;
    end else if (ce) begin
      in_full_q <= !ib_ready || (ib_valid && !ib_pop && in_write && !in_full_q);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_exists_q <= 1'h0;
    end else if (ce) begin
      if (take) begin
        out_exists_q <= 1'h1;
      end else if (out_read) begin
        out_exists_q <= 1'h0;
      end
    end
  end

  // Word kept on empty: a read from empty returns the stale word
  always_ff @(posedge clk) begin
    if (ce && take) begin
      out_word_q <= ob_word;
    end
  end

  assign in_full    = in_full_q;
  assign out_exists = out_exists_q;
  assign out_word   = out_word_q;
endmodule

module slps_top #(
  parameter int unsigned LINKS = slps_pkg::LINK_NUM
) (
  // Clock, reset, enable
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire logic                              ce,
  // Processor command port
  input  wire logic                              cmd_valid,
  input  wire slps_pkg::slps_cmd_t               cmd,
  output logic                                   cmd_stall,
  output logic                                   cmd_done,
  output logic [slps_pkg::DATA_W-1:0]            cmd_rdata,
  output logic [31:0]                            processor_status_word,
  // Inbound user ports (user writes toward processor)
  input  wire logic [LINKS-1:0]                  in_write,
  input  wire slps_pkg::slps_word_t [LINKS-1:0]  in_word,
  output logic [LINKS-1:0]                       in_full,
  // Outbound user ports (user reads from processor)
  input  wire logic [LINKS-1:0]                  out_read,
  output slps_pkg::slps_word_t [LINKS-1:0]       out_word,
  output logic [LINKS-1:0]                       out_exists
);
  if (LINKS < 1 || LINKS > slps_pkg::LINK_NUM) begin : g_bad_links
    $error("slps_top: LINKS must be 1 to 8");
  end
  if ((1 << slps_pkg::LINK_IDX_W) < LINKS) begin : g_bad_idx
    $error("slps_top: link index too narrow for LINKS");
  end
  if (slps_pkg::DATA_W != 32) begin : g_bad_data_w
    $error("slps_top: data lane must match the 32-bit status word");
  end

  // Per-link processor side signals
  logic [LINKS-1:0]                 ib_valid;
  slps_pkg::slps_word_t [LINKS-1:0] ib_word;
  logic [LINKS-1:0]                 ib_pop;
  logic [LINKS-1:0]                 ob_ready;
  logic [LINKS-1:0]                 ob_push;
  slps_pkg::slps_word_t             ob_in;

  // Link index equals connection index; user-side outputs stay flopped in each lane
  genvar g;
  generate
    for (g = 0; g < LINKS; g++) begin : g_link
      slps_lane #(.W(slps_pkg::DATA_W + 1)) u_lane (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .ce         (ce),
        .in_write   (in_write[g]),
        .in_word    (in_word[g]),
        .in_full    (in_full[g]),
        .ib_valid   (ib_valid[g]),
        .ib_pop     (ib_pop[g]),
        .ib_word    (ib_word[g]),
        .ob_push    (ob_push[g]),
        .ob_ready   (ob_ready[g]),
        .ob_in      (ob_in),
        .out_read   (out_read[g]),
        .out_word   (out_word[g]),
        .out_exists (out_exists[g])
      );
    end
  endgenerate

  // Processor side
  logic                 sel_avail;
  slps_pkg::slps_word_t sel_word;
  logic                 can_go;
  logic                 fail_inv;
  logic                 fail_tag;
  logic                 is_rd;
  logic                 is_wr;

  assign is_rd     = cmd_valid && (cmd.op == slps_pkg::SLPS_OP_READ);
  assign is_wr     = cmd_valid && (cmd.op == slps_pkg::SLPS_OP_WRITE);
  assign sel_avail = is_rd ? ib_valid[cmd.link] : ob_ready[cmd.link];
  assign sel_word  = ib_word[cmd.link];
  assign can_go    = sel_avail && (int'(cmd.link) < LINKS);
  assign fail_inv  = (is_rd || is_wr) && !can_go;
  assign fail_tag  = is_rd && can_go && (sel_word.tag != cmd.control);

  // Blocking transfers hold until the link is ready
  assign cmd_stall = cmd_valid && cmd.blocking && fail_inv;

  always_comb begin
    ob_push = '0;
    ib_pop  = '0;
    if (is_wr && can_go && !cmd_stall && ce) begin
      ob_push[cmd.link] = 1'h1;
    end
    if (is_rd && can_go && !cmd_stall) begin
      ib_pop[cmd.link] = 1'h1;
    end
  end

  assign ob_in.data = cmd.data;
  assign ob_in.tag  = cmd.control ? slps_pkg::TAG_CONTROL : slps_pkg::TAG_DATA;

  slps_pkg::slps_state_t state_q;
  logic [31:0]           rdata_q;
  logic [31:0]           stat_q;
  logic                  accept;

  assign accept = cmd_valid && !cmd_stall;

  // Command tracker: done is the one-cycle state after an accept
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= slps_pkg::SLPS_ST_IDLE;
    end else if (ce) begin
      unique case (state_q)
        slps_pkg::SLPS_ST_IDLE,
        slps_pkg::SLPS_ST_DONE: begin
          if (accept) begin
            state_q <= slps_pkg::SLPS_ST_DONE;
          end else if (cmd_stall) begin
            state_q <= slps_pkg::SLPS_ST_WAIT;
          end else begin
            state_q <= slps_pkg::SLPS_ST_IDLE;
          end
        end
        slps_pkg::SLPS_ST_WAIT: begin
          if (accept) begin
            state_q <= slps_pkg::SLPS_ST_DONE;
          end else if (!cmd_stall) begin
            state_q <= slps_pkg::SLPS_ST_IDLE;
          end
        end
        default: begin
          state_q <= slps_pkg::SLPS_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (ce && cmd_valid && !cmd_stall) begin
      if (cmd.op == slps_pkg::SLPS_OP_STAT) begin
        rdata_q <= stat_q;
      end else if (is_rd) begin
        rdata_q <= sel_word.data;
      end
    end
  end

  // Only link instructions touch the flags; a status move leaves them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_q <= slps_pkg::STAT_RESET;
    end else if (ce && (is_rd || is_wr) && !cmd_stall) begin
      stat_q[slps_pkg::STAT_CARRY_POS] <= fail_inv;
      stat_q[slps_pkg::STAT_MSB_POS]   <= fail_inv;
      stat_q[slps_pkg::STAT_LERR_POS]  <= fail_tag;
    end
  end

  assign cmd_done              = |(state_q & slps_pkg::SLPS_ST_DONE);
  assign cmd_rdata             = rdata_q;
  assign processor_status_word = stat_q;
endmodule

/* slps_monitor.sv */
// Port checker for slps_top command and status side.
// Bound from the bench; one clock domain, async reset.
`timescale 1ns/1ps
module slps_monitor #(
  parameter int unsigned LINKS = 8
) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic                ce,
  // Command port
  input wire logic                cmd_valid,
  input wire slps_pkg::slps_cmd_t cmd,
  input wire logic                cmd_stall,
  input wire logic                cmd_done,
  input wire logic [31:0]         cmd_rdata,
  // Status
  input wire logic [31:0]         processor_status_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic acc, stat_acc;
  assign acc = cmd_valid && !cmd_stall && ce;
  assign stat_acc = acc && cmd.op == slps_pkg::SLPS_OP_STAT;
  chk_done_after_acc: assert property (acc |=> cmd_done)
    else $error("done missing after accept");
  chk_done_cause: assert property (cmd_done |-> $past(acc))
    else $error("done without accept");
  chk_nb_no_stall: assert property (cmd_valid && !cmd.blocking |-> !cmd_stall)
    else $error("non-blocking op stalled");
  chk_stall_blocking: assert property (cmd_stall |-> cmd_valid && cmd.blocking)
    else $error("stall without blocking op");
  chk_carry_copy: assert property (processor_status_word[31] == processor_status_word[2])
    else $error("carry copy differs");
  // Only bit 0, bit 27 and bit 29 may ever be set
  chk_spare_zero: assert property ((processor_status_word & 32'h7fff_ffeb) == 32'h0)
    else $error("spare status bit set");
  chk_stat_move: assert property (stat_acc |=> cmd_rdata == $past(processor_status_word)
                                  && $stable(processor_status_word))
    else $error("status move wrong");
  chk_flags_hold: assert property (!(acc && !stat_acc) |=> $stable(processor_status_word))
    else $error("flags moved without link op");
  chk_blk_ok: assert property (acc && cmd.blocking && !stat_acc |=> !processor_status_word[2])
    else $error("blocking op reported carry");
endmodule

/* slps_user_model.sv */
// Far-side user logic: pushes tagged words inbound, drains outbound.
// Shares the processor clock; the bench sets drain and calls send.
`timescale 1ns/1ps
module slps_user_model (
  // Clock and bench control
  input wire logic                   clk,
  input wire logic                   drain,
  // Inbound side
  input wire logic [7:0]             in_full,
  output slps_pkg::slps_word_t [7:0] in_word,
  output logic [7:0]                 in_write,
  // Outbound side
  input wire logic [7:0]             out_exists,
  output logic [7:0]                 out_read
);
  int n_pop = 0;
  initial begin
    in_write = 8'h00;
    in_word = '0;
  end
  // Reads only while a word is present; drain low models a stall
  assign out_read = drain ? out_exists : 8'h00;
  always @(posedge clk) n_pop <= n_pop + $countones(out_read & out_exists);
  task automatic send(input int k, input slps_pkg::slps_word_t w);
    int n;
    n = 0;
    while (in_full[k] !== 1'b0 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    in_write[k] <= 1'b1;
    in_word[k] <= w;
    @(posedge clk);
    in_write[k] <= 1'b0;
    // Released lane shows the inverse, not a stale copy
    in_word[k] <= ~w;
    #1;
  endtask
endmodule

/* slps_tb_top.sv */
// Bench for slps_top: command tasks, user model on the far side.
// Assumes package, design, model and checker compiled first.
`timescale 1ns/1ps
module slps_tb_top;
  localparam slps_pkg::slps_op_t RD = slps_pkg::SLPS_OP_READ, WR = slps_pkg::SLPS_OP_WRITE;
  logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, cmd_valid = 1'b0, drain = 1'b0, cmd_stall, cmd_done;
  slps_pkg::slps_cmd_t cmd = '0;
  logic [31:0] cmd_rdata, psw;
  logic [7:0] in_write, in_full, out_read, out_exists;
  slps_pkg::slps_word_t [7:0] in_word, out_word;
  int errors = 0, n_tests = 0, n;
  always #5 clk = ~clk;
  slps_top i_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_stall(cmd_stall),
    .cmd_done(cmd_done), .cmd_rdata(cmd_rdata), .processor_status_word(psw), .in_write(in_write),
    .in_word(in_word), .in_full(in_full), .out_read(out_read), .out_word(out_word), .out_exists(out_exists));
  slps_user_model i_user (.clk(clk), .drain(drain), .in_full(in_full), .in_word(in_word), .in_write(in_write),
    .out_exists(out_exists), .out_read(out_read));
  function automatic logic [32:0] sw(input int c, input int e);
    return {1'b0, c[0], 26'h0, e[0], 1'b0, c[0], 2'h0};
  endfunction
  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Request held from launch edge to accept edge
  task automatic run(input slps_pkg::slps_op_t op, input logic b, input logic c, input int k, input logic [31:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op, b, c, k[2:0], d};
    #1;
    for (n = 0; cmd_stall !== 1'b0 && n < 200; n++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk("done", 33'h1, {32'h0, cmd_done});
  endtask
  task automatic stall_then(input int k);
    repeat (6) @(posedge clk);
    #1;
    chk("stall", 33'h1, {32'h0, cmd_stall});
    if (k < 0) drain <= 1'b1;
    else i_user.send(k, {1'b0, 32'h66});
  endtask
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("reset", 33'h0, {1'b0, psw});
    chk("reset flags", 33'h0, {17'h0, in_full, out_exists});
    run(RD, 1'b0, 1'b0, 0, 32'h0);
    chk("empty read", sw(1, 0), {1'b0, psw});
    run(slps_pkg::SLPS_OP_STAT, 1'b0, 1'b0, 0, 32'h0);
    chk("status move", sw(1, 0), {1'b0, cmd_rdata});
    for (int k = 0; k < 8; k++) begin
      run(WR, 1'b0, k[0], k, 32'h5a00 + k);
      chk("write status", sw(0, 0), {1'b0, psw});
      for (n = 0; out_exists[k] !== 1'b1 && n < 10; n++) @(posedge clk);
      #1;
      chk("outbound word", {k[0], 32'h5a00 + k}, out_word[k]);
    end
    for (int i = 0; i < 3; i++) begin
      run(WR, 1'b0, 1'b0, 2, i);
      chk("fill status", sw(i == 2, 0), {1'b0, psw});
    end
    fork
      run(WR, 1'b1, 1'b0, 2, 32'hb10c);
      stall_then(-1);
    join
    chk("blocking write", sw(0, 0), {1'b0, psw});
    repeat (20) @(posedge clk);
    #1;
    chk("drained", 33'h0, {25'h0, out_exists});
    chk("pops", 33'd11, i_user.n_pop);
    for (int k = 0; k < 8; k++) begin
      i_user.send(k, {~k[0], 32'hc300 + k});
      run(RD, 1'b0, k[1], k, 32'h0);
      chk("inbound data", 32'hc300 + k, {1'b0, cmd_rdata});
      chk("read status", sw(0, ~k[0] != k[1]), {1'b0, psw});
    end
    i_user.send(4, {1'b0, 32'h1});
    i_user.send(4, {1'b0, 32'h2});
    repeat (2) @(posedge clk);
    #1;
    chk("inbound full", 33'h1, {32'h0, in_full[4]});
    run(RD, 1'b1, 1'b0, 4, 32'h0);
    chk("oldest first", 33'h1, {1'b0, cmd_rdata});
    run(RD, 1'b1, 1'b0, 4, 32'h0);
    chk("second word", 33'h2, {1'b0, cmd_rdata});
    fork
      run(RD, 1'b1, 1'b0, 4, 32'h0);
      stall_then(4);
    join
    chk("late word", 33'h66, {1'b0, cmd_rdata});
    chk("late status", sw(0, 0), {1'b0, psw});
    // Enable low: an empty read must neither complete nor touch the flags
    @(posedge clk);
    ce <= 1'b0;
    cmd_valid <= 1'b1;
    cmd <= '{RD, 1'b0, 1'b0, 3'h5, 32'h0};
    repeat (3) @(posedge clk);
    #1;
    chk("frozen done", 33'h0, {32'h0, cmd_done});
    chk("frozen status", sw(0, 0), {1'b0, psw});
    @(posedge clk);
    ce <= 1'b1;
    cmd_valid <= 1'b0;
    close_out();
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    close_out();
  end
endmodule
bind slps_top slps_monitor #(.LINKS(LINKS)) i_mon (.clk(clk), .sys_rst(sys_rst), .ce(ce), .cmd_valid(cmd_valid),
  .cmd(cmd), .cmd_stall(cmd_stall), .cmd_done(cmd_done), .cmd_rdata(cmd_rdata),
  .processor_status_word(processor_status_word));
